//--- hdl/diag_consts.svh
// byte offsets, field positions, reset values and timing figures of the diagnostic flag block
//
// Overview of operation
// R01: alarm byte 112 bits 7..0 flag temp, supply, bias, tx power high/low alarms
// R02: byte 113 bit 7/6 flag rx power high/low alarm; bits 0-5 reserved
// R03: warning byte 116 uses the alarm byte bit order for warning thresholds
// R04: byte 117 bit 7/6 flag rx power high/low warning; bits 0-5 reserved
// R05: byte 111 bit 3 is the host read/write tx rate control bit
// R06: effective tx rate select is soft bit OR external tx rate pin
// R07: byte 111 bit 1, power level state, always reads zero
// R08: byte 111 bit 0, power level select, has no effect
// R09: byte 40 holds 3-bit tx equalization used at high tx rate
// R10: byte 41 holds 3-bit tx equalization used at low tx rate
// R11: writing FFh or power cycle restores equalization bytes to 04h
// R12: byte 42 holds 4-bit rx pre-emphasis used at high rx rate
// R13: byte 43 holds 4-bit rx pre-emphasis used at low rx rate
// R14: writing FFh to byte 42 restores it to 03h
// R15: writing FFh to byte 43 or power cycle restores it to 02h
// R16: checksum byte 95 follows signal-integrity byte changes within 100 ms
// R17: these bytes are reached through the second two-wire device address
// R18: soft command writes take effect within 100 ms
// R19: temperature compares as 16-bit signed two's complement, 1/256 degree steps
// R20: flags are re-evaluated from latest values at every monitor update
// R21: reserved flag and soft-command bits read zero, writes ignored
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH

// ****************************************
// two-wire addressing
// ****************************************
`define DEV_ADDR_A2      7'h51
`define BYTE_TX_EQ_HI    8'h28
`define BYTE_TX_EQ_LO    8'h29
`define BYTE_RX_EM_HI    8'h2A
`define BYTE_RX_EM_LO    8'h2B
`define BYTE_CHECKSUM    8'h5F
`define BYTE_SOFT_CTRL   8'h6F
`define BYTE_ALARM_P     8'h70
`define BYTE_ALARM_RX    8'h71
`define BYTE_WARN_P      8'h74
`define BYTE_WARN_RX     8'h75

// ****************************************
// fields and values
// ****************************************
`define SOFT_TX_BIT      3
`define RX_HI_BIT        7
`define RX_LO_BIT        6
`define RESTORE_CODE     8'hFF
`define TX_EQ_DEFAULT    8'h04
`define RX_EM_HI_DEFAULT 8'h03
`define RX_EM_LO_DEFAULT 8'h02
`define BITS_PER_BYTE    4'h8
`define CH_TEMP          0
`define CH_RX_POWER      4
`define NUM_PRIMARY_CH   4
// scl and sda idle high, rate pins idle low: no false edge or false high rate after reset
`define PIN_SYNC_IDLE    4'hC

// ****************************************
// timing
// ****************************************
`define SOFT_RESP_MS     100

`endif

//--- hdl/diag_pkg.sv
// types shared by the diagnostic flag block
package diag_pkg;

  typedef logic [15:0] mon_word_t;

  typedef struct packed {
    mon_word_t high_alarm;
    mon_word_t low_alarm;
    mon_word_t high_warning;
    mon_word_t low_warning;
  } channel_limits_t;

  typedef struct packed {
    logic high_alarm;
    logic low_alarm;
    logic high_warning;
    logic low_warning;
  } channel_flags_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } byte_write_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WORD,
    ST_WORD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } link_state_t;

endpackage : diag_pkg

//--- hdl/threshold_compare.sv
// one monitor channel against its four thresholds
`timescale 1ns/1ps
`default_nettype none

module threshold_compare
  import diag_pkg::*;
#(
  parameter bit IS_SIGNED = 1'b0
) (
  input  wire mon_word_t       value,
  input  wire channel_limits_t limits,
  output var channel_flags_t   flags
);

  // ****************************************
  // compare
  // ****************************************
  function automatic logic above(input mon_word_t a, input mon_word_t b);
    if (IS_SIGNED) begin
      above = $signed(a) > $signed(b); // R19
    end else begin
      above = a > b;
    end
  endfunction : above

  always_comb begin
    flags.high_alarm   = above(value, limits.high_alarm);
    flags.low_alarm    = above(limits.low_alarm, value);
    flags.high_warning = above(value, limits.high_warning);
    flags.low_warning  = above(limits.low_warning, value);
  end

endmodule : threshold_compare

`default_nettype wire

//--- hdl/diag_flag_si_config.sv
// flag, soft-command and signal-integrity bytes behind the second two-wire address
`timescale 1ns/1ps
`default_nettype none
`include "diag_consts.svh"

module diag_flag_si_config
  import diag_pkg::*;
#(
  parameter int NUM_CH = 5
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  input  wire logic                     tx_rate_pin,
  input  wire logic                     rx_rate_pin,
  input  wire logic                     mon_update,
  input  wire mon_word_t [NUM_CH-1:0]   mon_value,
  input  wire channel_limits_t [NUM_CH-1:0] mon_limits,
  input  wire logic [7:0]               base_sum,
  output logic                          tx_rate_select,
  output logic [2:0]                    tx_eq_code,
  output logic [3:0]                    rx_emph_code,
  output logic [7:0]                    checksum
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       scl_d;
  logic       sda_d;
  logic       scl_r;
  logic       sda_r;
  logic       tx_rate_s;
  logic       rx_rate_s;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_meta <= `PIN_SYNC_IDLE;
      pin_sync <= `PIN_SYNC_IDLE;
    end else begin
      pin_meta <= {scl_in, sda_in, tx_rate_pin, rx_rate_pin};
      pin_sync <= pin_meta;
    end
  end

  assign scl_r     = pin_sync[3];
  assign sda_r     = pin_sync[2];
  assign tx_rate_s = pin_sync[1];
  assign rx_rate_s = pin_sync[0];

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_r;
      sda_d <= sda_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl_r & ~scl_d;
  assign scl_fall   = ~scl_r & scl_d;
  assign start_cond = scl_r & scl_d & sda_d & ~sda_r;
  assign stop_cond  = scl_r & scl_d & ~sda_d & sda_r;

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] tx_eq_high_rate;
  logic [7:0] tx_eq_low_rate;
  logic [7:0] rx_emphasis_high_rate;
  logic [7:0] rx_emphasis_low_rate;
  logic       soft_tx_speed_bit;
  logic [7:0] alarm_flags_primary;
  logic [7:0] alarm_flags_rx_power;
  logic [7:0] warning_flags_primary;
  logic [7:0] warning_flags_rx_power;
  byte_write_t wr;

  // ****************************************
  // read decode
  // ****************************************
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    read_byte = 8'h00;
    unique case (a)
      `BYTE_TX_EQ_HI:  read_byte = tx_eq_high_rate;
      `BYTE_TX_EQ_LO:  read_byte = tx_eq_low_rate;
      `BYTE_RX_EM_HI:  read_byte = rx_emphasis_high_rate;
      `BYTE_RX_EM_LO:  read_byte = rx_emphasis_low_rate;
      `BYTE_CHECKSUM:  read_byte = checksum;
      // reserved and power bits read zero
      `BYTE_SOFT_CTRL: read_byte[`SOFT_TX_BIT] = soft_tx_speed_bit; // R05 R07 R21
      `BYTE_ALARM_P:   read_byte = alarm_flags_primary;
      `BYTE_ALARM_RX:  read_byte = alarm_flags_rx_power;
      `BYTE_WARN_P:    read_byte = warning_flags_primary;
      `BYTE_WARN_RX:   read_byte = warning_flags_rx_power;
      default:         read_byte = 8'h00;
    endcase
  endfunction : read_byte

  // ****************************************
  // two-wire slave
  // ****************************************
  link_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx_byte;
  logic [7:0]  ptr;
  logic        rw_read;
  logic        host_nack;
  logic [7:0]  rd_next;

  // byte to send next, held apart so its msb can be picked
  always_comb begin
    rd_next = read_byte(ptr);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      tx_byte   <= 8'h00;
      ptr       <= 8'h00;
      rw_read   <= 1'b0;
      host_nack <= 1'b0;
      sda_oe    <= 1'b0;
      wr        <= '0;
    end else begin
      wr.en <= 1'b0;
      if (start_cond) begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_cond) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          ST_ADDR, ST_WORD, ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_r};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RDATA: begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RDATA_ACK: begin
            host_nack <= sda_r;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state)
          ST_ADDR: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              if (shreg[7:1] == `DEV_ADDR_A2) begin // R17
                state   <= ST_ADDR_ACK;
                rw_read <= shreg[0];
                sda_oe  <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt <= 4'h0;
            if (rw_read) begin
              state   <= ST_RDATA;
              tx_byte <= rd_next;
              sda_oe  <= ~rd_next[7];
            end else begin
              state  <= ST_WORD;
              sda_oe <= 1'b0;
            end
          end
          ST_WORD: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              state  <= ST_WORD_ACK;
              ptr    <= shreg;
              sda_oe <= 1'b1;
            end
          end
          ST_WDATA: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              state   <= ST_WDATA_ACK;
              wr.en   <= 1'b1;
              wr.addr <= ptr;
              wr.data <= shreg;
              sda_oe  <= 1'b1;
            end
          end
          ST_WORD_ACK, ST_WDATA_ACK: begin
            if (state == ST_WDATA_ACK) begin
              ptr <= ptr + 8'h01;
            end
            state   <= ST_WDATA;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
          end
          ST_RDATA: begin
            if (bit_cnt == `BITS_PER_BYTE) begin
              state  <= ST_RDATA_ACK;
              ptr    <= ptr + 8'h01;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~tx_byte[3'h7 - bit_cnt[2:0]];
            end
          end
          ST_RDATA_ACK: begin
            if (host_nack) begin
              state <= ST_IDLE;
            end else begin
              state   <= ST_RDATA;
              bit_cnt <= 4'h0;
              tx_byte <= rd_next;
              sda_oe  <= ~rd_next[7];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ****************************************
  // soft command byte
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      soft_tx_speed_bit <= 1'b0;
    end else if (wr.en && wr.addr == `BYTE_SOFT_CTRL) begin
      // power select and reserved bits are dropped
      soft_tx_speed_bit <= wr.data[`SOFT_TX_BIT]; // R05 R08 R18 R21
    end
  end

  // ****************************************
  // signal-integrity bytes
  // ****************************************
  function automatic logic [7:0] si_next(input logic [7:0] d, input logic [7:0] dflt);
    si_next = (d == `RESTORE_CODE) ? dflt : d;
  endfunction : si_next

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_eq_high_rate       <= `TX_EQ_DEFAULT;    // R11
      tx_eq_low_rate        <= `TX_EQ_DEFAULT;    // R11
      rx_emphasis_high_rate <= `RX_EM_HI_DEFAULT;
      rx_emphasis_low_rate  <= `RX_EM_LO_DEFAULT; // R15
    end else if (wr.en) begin
      unique case (wr.addr)
        `BYTE_TX_EQ_HI: tx_eq_high_rate       <= si_next(wr.data, `TX_EQ_DEFAULT);    // R09 R11
        `BYTE_TX_EQ_LO: tx_eq_low_rate        <= si_next(wr.data, `TX_EQ_DEFAULT);    // R10 R11
        `BYTE_RX_EM_HI: rx_emphasis_high_rate <= si_next(wr.data, `RX_EM_HI_DEFAULT); // R12 R14
        `BYTE_RX_EM_LO: rx_emphasis_low_rate  <= si_next(wr.data, `RX_EM_LO_DEFAULT); // R13 R15
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // rate selection and analog codes
  // ****************************************
  logic eff_tx_rate;

  assign eff_tx_rate = soft_tx_speed_bit | tx_rate_s; // R06

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_rate_select <= 1'b0;
      tx_eq_code     <= 3'h0;
      rx_emph_code   <= 4'h0;
    end else begin
      tx_rate_select <= eff_tx_rate; // R06 R18
      tx_eq_code     <= eff_tx_rate ? tx_eq_high_rate[2:0] : tx_eq_low_rate[2:0]; // R09 R10
      rx_emph_code   <= rx_rate_s ? rx_emphasis_high_rate[3:0]
                                  : rx_emphasis_low_rate[3:0]; // R12 R13
    end
  end

  // ****************************************
  // checksum upkeep
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      checksum <= 8'h00;
    end else begin
      // follows any change one cycle later, far inside the deadline
      checksum <= base_sum + tx_eq_high_rate + tx_eq_low_rate
                  + rx_emphasis_high_rate + rx_emphasis_low_rate; // R16
    end
  end

  // ****************************************
  // threshold flags
  // ****************************************
  channel_flags_t [NUM_CH-1:0] ch_flags;

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      threshold_compare #(
        .IS_SIGNED (g == `CH_TEMP)
      ) u_cmp (
        .value  (mon_value[g]),
        .limits (mon_limits[g]),
        .flags  (ch_flags[g])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      alarm_flags_primary    <= 8'h00;
      warning_flags_primary  <= 8'h00;
      alarm_flags_rx_power   <= 8'h00;
      warning_flags_rx_power <= 8'h00;
    end else if (mon_update) begin // R20
      for (int c = 0; c < `NUM_PRIMARY_CH; c++) begin
        alarm_flags_primary[7-2*c]   <= ch_flags[c].high_alarm;   // R01
        alarm_flags_primary[6-2*c]   <= ch_flags[c].low_alarm;    // R01
        warning_flags_primary[7-2*c] <= ch_flags[c].high_warning; // R03
        warning_flags_primary[6-2*c] <= ch_flags[c].low_warning;  // R03
      end
      alarm_flags_rx_power <= 8'h00; // R21
      alarm_flags_rx_power[`RX_HI_BIT]   <= ch_flags[`CH_RX_POWER].high_alarm;   // R02
      alarm_flags_rx_power[`RX_LO_BIT]   <= ch_flags[`CH_RX_POWER].low_alarm;    // R02
      warning_flags_rx_power <= 8'h00; // R21
      warning_flags_rx_power[`RX_HI_BIT] <= ch_flags[`CH_RX_POWER].high_warning; // R04
      warning_flags_rx_power[`RX_LO_BIT] <= ch_flags[`CH_RX_POWER].low_warning;  // R04
    end
  end

endmodule : diag_flag_si_config

`default_nettype wire

//--- tb/diag_host_model.sv
// host controller model on the two-wire management bus
`timescale 1ns/1ps
`default_nettype none

module diag_host_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_h
);
  // ****************************************
  // bus phases of six clocks each
  // ****************************************
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end

  task automatic half;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : half

  // sda falls while scl is high: start or repeated start
  task automatic start;
    sda_h = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_h = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start

  task automatic stop;
    sda_h = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_h = 1'b1;
    half();
  endtask : stop

  // eight data bits then the acknowledge bit; sda only moves while scl is low
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic [8:0] w;
    logic [8:0] r;
    w = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_h = w[i];
      half();
      scl = 1'b1;
      half();
      r[i] = sda;
      scl = 1'b0;
      half();
    end
    q = r[8:1];
    ack = r[0];
  endtask : xfer
endmodule : diag_host_model
`default_nettype wire

//--- tb/diag_flag_si_config_sva.sv
// assertions on the pins of the diagnostic flag block
`timescale 1ns/1ps
`default_nettype none

module diag_flag_si_config_sva (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       tx_rate_pin,
  input wire logic       rx_rate_pin,
  input wire logic       mon_update,
  input wire logic [7:0] base_sum,
  input wire logic       tx_rate_select,
  input wire logic [2:0] tx_eq_code,
  input wire logic [3:0] rx_emph_code,
  input wire logic [7:0] checksum
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_sda_out_low: assert property (sda_out == 1'b0)
    else $error("sda_out left the open-drain low level");
  a_reset_quiet: assert property ($rose(rstn) |-> !sda_oe && !tx_rate_select && checksum == 8'h00)
    else $error("outputs not quiet at reset release");
  a_eq_default: assert property ($rose(rstn) |-> ##2 tx_eq_code == 3'h4)
    else $error("tx equalization not at default after reset");
  a_em_default: assert property ($rose(rstn) |-> ##2 rx_emph_code inside {4'h2, 4'h3})
    else $error("rx emphasis not at default after reset");
  a_tx_pin_or: assert property (tx_rate_pin [*5] |-> tx_rate_select)
    else $error("tx rate pin high but rate select low");
  a_sum_tracks: assert property (scl_in [*8] |-> checksum - $past(base_sum) == $past(checksum) - $past(base_sum, 2))
    else $error("checksum moved without a byte change");
  a_tx_code_hold: assert property ((scl_in && $stable(tx_rate_select)) [*8] |-> $stable(tx_eq_code))
    else $error("tx equalization code moved without cause");
  a_rx_code_hold: assert property ((scl_in && $stable(rx_rate_pin)) [*8] |-> $stable(rx_emph_code))
    else $error("rx emphasis code moved without cause");
  a_drive_on_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in) && !$past(scl_in, 2))
    else $error("sda drive changed while scl high");
  a_idle_release: assert property (scl_in [*8] |-> !sda_oe)
    else $error("sda driven on an idle bus");

  c_ack: cover property ($rose(sda_oe));
  c_update: cover property (mon_update);
  c_rate_high: cover property ($rose(tx_rate_select));
endmodule : diag_flag_si_config_sva

bind diag_flag_si_config diag_flag_si_config_sva chk (
  .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .tx_rate_pin(tx_rate_pin), .rx_rate_pin(rx_rate_pin), .mon_update(mon_update), .base_sum(base_sum),
  .tx_rate_select(tx_rate_select), .tx_eq_code(tx_eq_code), .rx_emph_code(rx_emph_code), .checksum(checksum)
);
`default_nettype wire

//--- tb/diag_flag_si_config_bench.sv
// self-checking bench of the diagnostic flag and signal-integrity block
`timescale 1ns/1ps
`default_nettype none
`include "diag_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module diag_flag_si_config_bench import diag_pkg::*;;
  logic                  ref_clk     = 1'b0;
  logic                  rstn        = 1'b0;
  logic                  tx_rate_pin = 1'b0;
  logic                  rx_rate_pin = 1'b0;
  logic                  mon_update  = 1'b0;
  logic [7:0]            base_sum    = 8'h3C;
  mon_word_t [4:0]       mon_value   = '0;
  channel_limits_t [4:0] mon_limits  = '0;
  logic                  scl, sda_h, sda_out, sda_oe, tx_rate_select;
  logic [2:0]            tx_eq_code;
  logic [3:0]            rx_emph_code;
  logic [7:0]            checksum;
  logic [7:0]            si_dflt [4] = '{8'h04, 8'h04, 8'h03, 8'h02};
  wire                   sda = sda_h & ~sda_oe;
  int                    fails = 0;
  int                    n_checks = 0;
  int                    cycles = 0;

  always #20 ref_clk = ~ref_clk;

  diag_flag_si_config dut (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .tx_rate_pin(tx_rate_pin), .rx_rate_pin(rx_rate_pin), .mon_update(mon_update), .mon_value(mon_value),
    .mon_limits(mon_limits), .base_sum(base_sum), .tx_rate_select(tx_rate_select), .tx_eq_code(tx_eq_code),
    .rx_emph_code(rx_emph_code), .checksum(checksum)
  );
  diag_host_model host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_h(sda_h));

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [2:0] k;
    host.start();
    host.xfer({`DEV_ADDR_A2, 1'b0}, 1'b1, q, k[2]);
    host.xfer(a, 1'b1, q, k[1]);
    host.xfer(d, 1'b1, q, k[0]);
    host.stop();
    `CHK("write acks", 3'b000, k)
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic [3:0] k;
    host.start();
    host.xfer({`DEV_ADDR_A2, 1'b0}, 1'b1, q, k[3]);
    host.xfer(a, 1'b1, q, k[2]);
    host.start();
    host.xfer({`DEV_ADDR_A2, 1'b1}, 1'b1, q, k[1]);
    host.xfer(8'hFF, 1'b1, q, k[0]);
    host.stop();
    `CHK("read acks", 4'b0001, k)
    `CHK(nm, e, q)
  endtask : rd_chk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] q;
    logic [7:0] q2;
    logic [4:0] k;
    for (int i = 0; i < 4; i++) begin
      rd_chk("si default", 8'(8'h28 + i), si_dflt[i]);
    end
    rd_chk("soft byte", `BYTE_SOFT_CTRL, 8'h00);
    rd_chk("unmapped byte", 8'h2C, 8'h00);
    rd_chk("checksum byte", `BYTE_CHECKSUM, 8'h49);
    // two-byte read: host acks the first byte, pointer steps to the next
    host.start();
    host.xfer({`DEV_ADDR_A2, 1'b0}, 1'b1, q, k[4]);
    host.xfer(`BYTE_RX_EM_HI, 1'b1, q, k[3]);
    host.start();
    host.xfer({`DEV_ADDR_A2, 1'b1}, 1'b1, q, k[2]);
    host.xfer(8'hFF, 1'b0, q, k[1]);
    host.xfer(8'hFF, 1'b1, q2, k[0]);
    host.stop();
    `CHK("burst acks", 5'b00001, k)
    `CHK("burst first byte", 8'h03, q)
    `CHK("burst second byte", 8'h02, q2)
    `CHK("tx eq code", 3'h4, tx_eq_code)
    `CHK("rx emph code", 4'h2, rx_emph_code)
    `CHK("checksum", 8'h49, checksum)
    $display("test reset done");
  endtask : t_reset

  task automatic t_si;
    logic [7:0] val [4] = '{8'hFD, 8'h0B, 8'h3A, 8'h07};
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h28 + i), val[i]);
    end
    rd_chk("tx eq byte", `BYTE_TX_EQ_HI, 8'hFD);
    `CHK("tx eq low rate", 3'h3, tx_eq_code)
    `CHK("rx emph low rate", 4'h7, rx_emph_code)
    `CHK("checksum", 8'h85, checksum)
    tx_rate_pin = 1'b1;
    rx_rate_pin = 1'b1;
    tick(8);
    `CHK("tx eq high rate", 3'h5, tx_eq_code)
    `CHK("rx emph high rate", 4'hA, rx_emph_code)
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h28 + i), `RESTORE_CODE);
      rd_chk("si restore", 8'(8'h28 + i), si_dflt[i]);
    end
    base_sum = 8'h10;
    tx_rate_pin = 1'b0;
    rx_rate_pin = 1'b0;
    tick(8);
    `CHK("checksum rebased", 8'h1D, checksum)
    $display("test si done");
  endtask : t_si

  task automatic t_soft;
    wr(`BYTE_SOFT_CTRL, 8'hFF);
    rd_chk("soft byte all", `BYTE_SOFT_CTRL, 8'h08);
    `CHK("rate by soft bit", 1'b1, tx_rate_select)
    wr(`BYTE_SOFT_CTRL, 8'h01);
    rd_chk("power select", `BYTE_SOFT_CTRL, 8'h00);
    `CHK("rate released", 1'b0, tx_rate_select)
    tx_rate_pin = 1'b1;
    tick(8);
    `CHK("rate by pin", 1'b1, tx_rate_select)
    tx_rate_pin = 1'b0;
    wr(`BYTE_ALARM_P, 8'hFF);
    rd_chk("flag byte read only", `BYTE_ALARM_P, 8'h00);
    $display("test soft done");
  endtask : t_soft

  task automatic t_flags;
    logic [7:0] addr [4] = '{`BYTE_ALARM_P, `BYTE_ALARM_RX, `BYTE_WARN_P, `BYTE_WARN_RX};
    logic [7:0] hit [4] = '{8'h48, 8'h80, 8'h69, 8'h80};
    for (int i = 0; i < 5; i++) begin
      mon_limits[i] = '{16'h03E8, 16'h0064, 16'h0320, 16'h00C8};
    end
    // negative temperature trips the low limits only when compared signed
    mon_value = {16'h07D0, 16'h0096, 16'h05DC, 16'h0384, 16'hFFFB};
    for (int r = 0; r < 2; r++) begin
      mon_update = 1'b1;
      tick(1);
      mon_update = 1'b0;
      for (int i = 0; i < 4; i++) begin
        rd_chk("flag byte", addr[i], (r == 0) ? hit[i] : 8'h00);
      end
      mon_value = {5{16'h01F4}};
    end
    $display("test flags done");
  endtask : t_flags

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    tick(8);
    rstn = 1'b1;
    tick(8);
    t_reset();
    t_si();
    t_soft();
    t_flags();
    report_and_stop();
  end
endmodule : diag_flag_si_config_bench
`default_nettype wire
